// [rtl/pcca_regs.svh]
`ifndef PCCA_REGS_SVH
`define PCCA_REGS_SVH

// ****************************************
// Parameter selectors
// ****************************************
`define PCCA_SEL_COMMAND    4'h0
`define PCCA_SEL_ALARM      4'h1
`define PCCA_SEL_AIN1_TYPE  4'h2
`define PCCA_SEL_AIN2_TYPE  4'h3
`define PCCA_SEL_AIN2_FUNC  4'h4
`define PCCA_SEL_OFF_TIME   4'h5
`define PCCA_SEL_RAMP_TIME  4'h6
`define PCCA_SEL_CYCLE_TIME 4'h7
`define PCCA_SEL_DELAY      4'h8
`define PCCA_SEL_AIN1_VALUE 4'h9
`define PCCA_SEL_AIN2_VALUE 4'ha
`define PCCA_SEL_LINE_VOLT  4'hb
`define PCCA_SEL_DIG_IN1    4'hc
`define PCCA_SEL_STATUS     4'hd

// ****************************************
// Command word fields
// ****************************************
`define PCCA_CMD_LOCAL_SP   1
`define PCCA_CMD_ENABLE     2
`define PCCA_CMD_LOCAL_IL   4
`define PCCA_CMD_TOTAL_RST  11
`define PCCA_CMD_KEEP_MASK  16'h0016

// ****************************************
// Reset values and ranges
// ****************************************
`define PCCA_RST_COMMAND    16'h0000
`define PCCA_RST_TYPE       2'h1
`define PCCA_TYPE_MAX       2'h3
`define PCCA_RST_MINUTES    11'h001
`define PCCA_MINUTES_MAX    11'h7cf
`define PCCA_RST_CYCLE      8'h1e
`define PCCA_RST_DELAY      7'h3c
`define PCCA_DELAY_MAX      7'h5a
`define PCCA_PERCENT_MAX    10'h3e8

// ****************************************
// Timing
// ****************************************
`define PCCA_CLK_PERIOD_NS  10
`define PCCA_CYCLE_STEP_MS  50
`define PCCA_CYCLE_STEP_CYC ((`PCCA_CYCLE_STEP_MS * 1000000) / `PCCA_CLK_PERIOD_NS)
`define PCCA_MINUTE_S       60
`define PCCA_MINUTE_CYC     ((64'd`PCCA_MINUTE_S * 64'd1000000000) / 64'd`PCCA_CLK_PERIOD_NS)

`endif

// [rtl/pcca_pkg.sv]
package pcca_pkg;

	typedef enum logic [2:0] {
		ALARM_OVERTEMP_ONLY = 3'b000,
		ALARM_BREAK         = 3'b001,
		ALARM_SHORT         = 3'b010,
		ALARM_LIMIT         = 3'b011,
		ALARM_BREAK_SHORT   = 3'b100,
		ALARM_BREAK_LIMIT   = 3'b101,
		ALARM_SHORT_LIMIT   = 3'b110,
		ALARM_ALL           = 3'b111
	} pcca_alarm_sel_t;

	typedef enum logic [1:0] {
		AIN2_CURRENT_LIMIT = 2'b00,
		AIN2_FEEDBACK      = 2'b01,
		AIN2_SET_POINT     = 2'b10
	} pcca_ain2_func_t;

	typedef enum logic [1:0] {
		BAKE_IDLE = 2'b00,
		BAKE_RAMP = 2'b01
	} pcca_bake_state_t;

endpackage

// [rtl/pcca_cycle_timer.sv]
`timescale 1ns/1ps
`include "pcca_regs.svh"

module pcca_cycle_timer #(
	parameter int unsigned STEP_CYCLES = `PCCA_CYCLE_STEP_CYC
) (
	input  wire logic       ref_clk,
	input  wire logic       sys_rst,
	input  wire logic [7:0] cycleSteps,
	output logic            cycleStart
);
	import pcca_pkg::*;

	logic [31:0] stepCnt_reg;
	logic [7:0]  cycleCnt_reg;
	logic        cycleStart_reg;
	wire         stepDone  = (stepCnt_reg == STEP_CYCLES - 1);
	wire         cycleDone = stepDone && (cycleCnt_reg >= cycleSteps - 8'h01);

	// ****************************************
	// One cycle is cycleSteps times 50 ms
	// ****************************************
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			stepCnt_reg    <= 32'h0;
			cycleCnt_reg   <= 8'h0;
			cycleStart_reg <= 1'b0;
		end else begin
			stepCnt_reg    <= stepDone ? 32'h0 : stepCnt_reg + 32'h1;
			// Zero steps means no cycle at all
			cycleStart_reg <= cycleDone && (cycleSteps != 8'h0);
			if (cycleDone)
				cycleCnt_reg <= 8'h0;
			else if (stepDone)
				cycleCnt_reg <= cycleCnt_reg + 8'h1;
		end
	end

	assign cycleStart = cycleStart_reg;

endmodule // pcca_cycle_timer

// [rtl/pcca_core.sv]
`timescale 1ns/1ps
`include "pcca_regs.svh"

// Function
// - Over-temperature always raises the alarm
// - Relay energized only when on and healthy
// - Break and short monitored only when selected
// - Eight alarm selections, default heater break
// - Watchdog alarm selectable by software only
// - Analog type codes 1, 2, 3
// - Analog values read 0 to 100.0 percent
// - Second input function, variant dependent default
// - Line voltage reads 0 to 1023
// - Bakeout starts after enough off time, current-limit variant only
// - Bakeout ramp minutes 1 to 1999
// - Command weights 2, 4, 16
// - Bit 2 enables unless input owns enable
// - Bit 4 picks current limit source
// - Bit 11 resets the energy total
// - Other command bits ignored
// - Port 2 read-write: bit 1 picks set point
// - Port 2 read-write: input and bit 2 enable
// - Cycle time is count times 50 ms
// - Firing delay 0 to 90 degrees
// - Digital input 1 level readable
module pcca_core #(
	parameter bit          HAS_CURRENT_LIMIT = 1'b1,
	parameter longint      MINUTE_CYCLES     = `PCCA_MINUTE_CYC,
	parameter int unsigned STEP_CYCLES       = `PCCA_CYCLE_STEP_CYC
) (
	input  wire logic                   ref_clk,
	input  wire logic                   sys_rst,
	input  wire logic                   paramWrEn,
	input  wire logic [3:0]             paramSel,
	input  wire logic [15:0]            paramWrData,
	output logic [15:0]                 paramRdData,
	input  wire logic                   ctrlPowerOn,
	input  wire logic                   heatSinkHotPin,
	input  wire logic                   heaterBreakPin,
	input  wire logic                   shortedSwitchPin,
	input  wire logic                   currentLimitPin,
	input  wire logic                   digIn1Pin,
	input  wire logic                   digEnablePin,
	input  wire logic                   digLocalPin,
	input  wire logic                   digEnableAssigned,
	input  wire logic                   digLocalAssigned,
	input  wire logic                   port2ReadWrite,
	input  wire logic                   commWatchdogErr,
	input  wire logic [9:0]             ain1Raw,
	input  wire logic [9:0]             ain2Raw,
	input  wire logic [9:0]             lineVoltRaw,
	output logic                        alarmRelay,
	output logic                        heaterBreakMonEn,
	output logic                        shortedSwitchMonEn,
	output logic                        outputEnable,
	output logic                        localSetPoint,
	output logic                        localCurrentLimit,
	output logic                        energyTotalReset,
	output logic                        bakeoutActive,
	output logic                        cycleStart,
	output logic [1:0]                  ain1Type,
	output logic [1:0]                  ain2Type,
	output pcca_pkg::pcca_ain2_func_t   ain2Function,
	output logic [6:0]                  firingDelayDeg
);
	import pcca_pkg::*;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	localparam int NPIN = 7;
	logic [NPIN-1:0] pinMeta_reg;
	logic [NPIN-1:0] pinSync_reg;
	wire  [NPIN-1:0] pinRaw = {digLocalPin, digEnablePin, digIn1Pin, currentLimitPin,
		shortedSwitchPin, heaterBreakPin, heatSinkHotPin};

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pinMeta_reg <= '0;
			pinSync_reg <= '0;
		end else begin
			pinMeta_reg <= pinRaw;
			pinSync_reg <= pinMeta_reg;
		end
	end

	wire hotSync   = pinSync_reg[0];
	wire breakSync = pinSync_reg[1];
	wire shortSync = pinSync_reg[2];
	wire limitSync = pinSync_reg[3];
	wire din1Sync  = pinSync_reg[4];
	wire denSync   = pinSync_reg[5];
	wire dlocSync  = pinSync_reg[6];

	// ****************************************
	// Alarm selection decode
	// ****************************************
	function automatic logic [2:0] alarmIncludes(input pcca_alarm_sel_t sel);
		case (sel)
			ALARM_BREAK:       alarmIncludes = 3'b001;
			ALARM_SHORT:       alarmIncludes = 3'b010;
			ALARM_LIMIT:       alarmIncludes = 3'b100;
			ALARM_BREAK_SHORT: alarmIncludes = 3'b011;
			ALARM_BREAK_LIMIT: alarmIncludes = 3'b101;
			ALARM_SHORT_LIMIT: alarmIncludes = 3'b110;
			ALARM_ALL:         alarmIncludes = 3'b111;
			default:           alarmIncludes = 3'b000;
		endcase
	endfunction

	// ****************************************
	// Parameter registers
	// ****************************************
	logic [15:0]      cmd_reg;
	logic [15:0]      cmdApplied_reg;
	pcca_alarm_sel_t  alarmSel_reg;
	logic             watchdogSel_reg;
	logic [1:0]       ain1Type_reg;
	logic [1:0]       ain2Type_reg;
	pcca_ain2_func_t  ain2Func_reg;
	logic [10:0]      offTime_reg;
	logic [10:0]      rampTime_reg;
	logic [7:0]       cycleTime_reg;
	logic [6:0]       delay_reg;
	logic             totalReset_reg;

	wire wrCmd   = paramWrEn && (paramSel == `PCCA_SEL_COMMAND);
	wire wrAlarm = paramWrEn && (paramSel == `PCCA_SEL_ALARM);
	wire wrA1Typ = paramWrEn && (paramSel == `PCCA_SEL_AIN1_TYPE);
	wire wrA2Typ = paramWrEn && (paramSel == `PCCA_SEL_AIN2_TYPE);
	wire wrA2Fn  = paramWrEn && (paramSel == `PCCA_SEL_AIN2_FUNC);
	wire wrOff   = paramWrEn && (paramSel == `PCCA_SEL_OFF_TIME);
	wire wrRamp  = paramWrEn && (paramSel == `PCCA_SEL_RAMP_TIME);
	wire wrCycle = paramWrEn && (paramSel == `PCCA_SEL_CYCLE_TIME);
	wire wrDelay = paramWrEn && (paramSel == `PCCA_SEL_DELAY);

	// Out-of-range writes are dropped so a bad host cannot corrupt a setting
	wire [2:0]  wrAlarmSet = alarmIncludes(pcca_alarm_sel_t'(paramWrData[2:0]));
	wire        alarmOk    = HAS_CURRENT_LIMIT || !wrAlarmSet[2];
	wire [1:0]  wrType     = paramWrData[1:0];
	wire        typeOk     = (paramWrData[15:2] == 14'h0) && (wrType != 2'h0);
	wire        funcOk     = (paramWrData[15:2] == 14'h0) && (paramWrData[1:0] != 2'h3)
		&& (HAS_CURRENT_LIMIT || paramWrData[1:0] != AIN2_CURRENT_LIMIT);
	wire [10:0] wrMin      = paramWrData[10:0];
	wire        minOk      = (paramWrData[15:11] == 5'h0) && (wrMin != 11'h0)
		&& (wrMin <= `PCCA_MINUTES_MAX);
	wire        cycleOk    = (paramWrData[15:8] == 8'h0);
	wire        delayOk    = (paramWrData[15:7] == 9'h0)
		&& (paramWrData[6:0] <= `PCCA_DELAY_MAX);
	localparam pcca_ain2_func_t AIN2_RST = HAS_CURRENT_LIMIT ? AIN2_CURRENT_LIMIT
		: AIN2_FEEDBACK;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cmd_reg         <= `PCCA_RST_COMMAND;
			cmdApplied_reg  <= `PCCA_RST_COMMAND;
			alarmSel_reg    <= ALARM_BREAK;
			watchdogSel_reg <= 1'b0;
			ain1Type_reg    <= `PCCA_RST_TYPE;
			ain2Type_reg    <= `PCCA_RST_TYPE;
			ain2Func_reg    <= AIN2_RST;
			offTime_reg     <= `PCCA_RST_MINUTES;
			rampTime_reg    <= `PCCA_RST_MINUTES;
			cycleTime_reg   <= `PCCA_RST_CYCLE;
			delay_reg       <= `PCCA_RST_DELAY;
			totalReset_reg  <= 1'b0;
		end else begin
			if (wrCmd)
				cmd_reg <= paramWrData & `PCCA_CMD_KEEP_MASK;
			cmdApplied_reg <= cmd_reg;
			totalReset_reg <= wrCmd && paramWrData[`PCCA_CMD_TOTAL_RST];
			if (wrAlarm && alarmOk) begin
				alarmSel_reg    <= pcca_alarm_sel_t'(paramWrData[2:0]);
				watchdogSel_reg <= paramWrData[3];
			end
			if (wrA1Typ && typeOk)
				ain1Type_reg <= wrType;
			if (wrA2Typ && typeOk)
				ain2Type_reg <= wrType;
			if (wrA2Fn && funcOk)
				ain2Func_reg <= pcca_ain2_func_t'(paramWrData[1:0]);
			if (wrOff && minOk)
				offTime_reg <= wrMin;
			if (wrRamp && minOk)
				rampTime_reg <= wrMin;
			if (wrCycle && cycleOk)
				cycleTime_reg <= paramWrData[7:0];
			if (wrDelay && delayOk)
				delay_reg <= paramWrData[6:0];
		end
	end

	// ****************************************
	// Alarm and monitor enables
	// ****************************************
	wire [2:0] alarmSet   = alarmIncludes(alarmSel_reg);
	wire       breakMonEn = alarmSet[0];
	wire       shortMonEn = alarmSet[1];
	wire       alarmCond  = hotSync
		|| (breakMonEn && breakSync) || (shortMonEn && shortSync)
		|| (alarmSet[2] && limitSync) || (watchdogSel_reg && commWatchdogErr);
	logic alarmRelay_reg;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst)
			alarmRelay_reg <= 1'b0;
		else
			alarmRelay_reg <= ctrlPowerOn && !alarmCond;
	end

	// ****************************************
	// Command word steering
	// ****************************************
	wire cmdLocal  = cmdApplied_reg[`PCCA_CMD_LOCAL_SP];
	wire cmdEnable = cmdApplied_reg[`PCCA_CMD_ENABLE];
	wire enableNext = !digEnableAssigned ? cmdEnable
		: port2ReadWrite ? (denSync && cmdEnable) : denSync;
	wire localNext  = (port2ReadWrite || !digLocalAssigned) ? cmdLocal
		: dlocSync;
	logic outEn_reg;
	logic local_reg;
	logic localIl_reg;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			outEn_reg   <= 1'b0;
			local_reg   <= 1'b0;
			localIl_reg <= 1'b0;
		end else begin
			outEn_reg   <= enableNext;
			local_reg   <= localNext;
			localIl_reg <= cmdApplied_reg[`PCCA_CMD_LOCAL_IL];
		end
	end

	// ****************************************
	// Bakeout off-time and ramp timing
	// ****************************************
	// A 64-bit prescaler so one minute fits at 100 MHz
	logic [63:0]      minCnt_reg;
	logic [10:0]      offMin_reg;
	logic [10:0]      rampMin_reg;
	logic             prevEn_reg;
	pcca_bake_state_t bake_reg;
	wire              minTick   = (minCnt_reg == 64'(MINUTE_CYCLES - 1));
	wire              enRise    = outEn_reg && !prevEn_reg;
	wire              bakeStart = enRise && (offMin_reg >= offTime_reg)
		&& HAS_CURRENT_LIMIT;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			minCnt_reg  <= 64'h0;
			offMin_reg  <= 11'h0;
			rampMin_reg <= 11'h0;
			prevEn_reg  <= 1'b0;
			bake_reg    <= BAKE_IDLE;
		end else begin
			prevEn_reg <= outEn_reg;
			minCnt_reg <= (minTick || outEn_reg != prevEn_reg) ? 64'h0
				: minCnt_reg + 64'h1;
			if (outEn_reg)
				offMin_reg <= 11'h0;
			else if (minTick && offMin_reg != `PCCA_MINUTES_MAX)
				offMin_reg <= offMin_reg + 11'h1;
			case (bake_reg)
				BAKE_IDLE: begin
					rampMin_reg <= 11'h0;
					if (bakeStart)
						bake_reg <= BAKE_RAMP;
				end
				BAKE_RAMP: begin
					if (!outEn_reg)
						bake_reg <= BAKE_IDLE;
					else if (minTick) begin
						rampMin_reg <= rampMin_reg + 11'h1;
						if (rampMin_reg + 11'h1 >= rampTime_reg)
							bake_reg <= BAKE_IDLE;
					end
				end
				default: bake_reg <= BAKE_IDLE;
			endcase
		end
	end

	// ****************************************
	// Measurements and readback
	// ****************************************
	logic [9:0] ain1Val_reg;
	logic [9:0] ain2Val_reg;
	logic [9:0] lineVolt_reg;
	wire  [9:0] ain1Clip = (ain1Raw > `PCCA_PERCENT_MAX) ? `PCCA_PERCENT_MAX : ain1Raw;
	wire  [9:0] ain2Clip = (ain2Raw > `PCCA_PERCENT_MAX) ? `PCCA_PERCENT_MAX : ain2Raw;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ain1Val_reg  <= 10'h0;
			ain2Val_reg  <= 10'h0;
			lineVolt_reg <= 10'h0;
		end else begin
			ain1Val_reg  <= ain1Clip;
			ain2Val_reg  <= ain2Clip;
			lineVolt_reg <= lineVoltRaw;
		end
	end

	wire [15:0] statusWord = {9'h0, bake_reg == BAKE_RAMP, local_reg, outEn_reg,
		hotSync, limitSync, shortSync, breakSync};
	wire [15:0] rdMux =
		(paramSel == `PCCA_SEL_COMMAND)    ? cmd_reg :
		(paramSel == `PCCA_SEL_ALARM)      ? {12'h0, watchdogSel_reg, alarmSel_reg} :
		(paramSel == `PCCA_SEL_AIN1_TYPE)  ? {14'h0, ain1Type_reg} :
		(paramSel == `PCCA_SEL_AIN2_TYPE)  ? {14'h0, ain2Type_reg} :
		(paramSel == `PCCA_SEL_AIN2_FUNC)  ? {14'h0, ain2Func_reg} :
		(paramSel == `PCCA_SEL_OFF_TIME)   ? {5'h0, offTime_reg} :
		(paramSel == `PCCA_SEL_RAMP_TIME)  ? {5'h0, rampTime_reg} :
		(paramSel == `PCCA_SEL_CYCLE_TIME) ? {8'h0, cycleTime_reg} :
		(paramSel == `PCCA_SEL_DELAY)      ? {9'h0, delay_reg} :
		(paramSel == `PCCA_SEL_AIN1_VALUE) ? {6'h0, ain1Val_reg} :
		(paramSel == `PCCA_SEL_AIN2_VALUE) ? {6'h0, ain2Val_reg} :
		(paramSel == `PCCA_SEL_LINE_VOLT)  ? {6'h0, lineVolt_reg} :
		(paramSel == `PCCA_SEL_DIG_IN1)    ? {15'h0, din1Sync} :
		(paramSel == `PCCA_SEL_STATUS)     ? statusWord : 16'h0;
	logic [15:0] rdData_reg;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst)
			rdData_reg <= 16'h0;
		else
			rdData_reg <= rdMux;
	end

	pcca_cycle_timer #(
		.STEP_CYCLES (STEP_CYCLES)
	) cycleTimer (
		.ref_clk     (ref_clk),
		.sys_rst     (sys_rst),
		.cycleSteps  (cycleTime_reg),
		.cycleStart  (cycleStart)
	);

	assign paramRdData        = rdData_reg;
	assign alarmRelay         = alarmRelay_reg;
	assign heaterBreakMonEn   = breakMonEn;
	assign shortedSwitchMonEn = shortMonEn;
	assign outputEnable       = outEn_reg;
	assign localSetPoint      = local_reg;
	assign localCurrentLimit  = localIl_reg;
	assign energyTotalReset   = totalReset_reg;
	assign bakeoutActive      = (bake_reg == BAKE_RAMP);
	assign ain1Type           = ain1Type_reg;
	assign ain2Type           = ain2Type_reg;
	assign ain2Function       = ain2Func_reg;
	assign firingDelayDeg     = delay_reg;

	// ****************************************
	// Assertions
	// ****************************************
	sequence hotSeen;
		hotSync;
	endsequence

	overtemp_alarm_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		hotSeen |=> !alarmRelay) else $error("overtemp did not drop relay");
	relay_off_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!ctrlPowerOn |=> !alarmRelay) else $error("relay energized while off");
	relay_healthy_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(ctrlPowerOn && !alarmCond) |=> alarmRelay) else $error("relay not energized");
	break_ignored_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(!alarmSet[0] && breakSync && !hotSync && !alarmSet[2] && !watchdogSel_reg
		&& !(alarmSet[1] && shortSync) && ctrlPowerOn) |=> alarmRelay)
		else $error("unselected break raised alarm");
	limit_variant_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!HAS_CURRENT_LIMIT |-> !alarmSet[2]) else $error("limit selection on plain variant");
	type_range_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		ain1Type_reg != 2'h0 && ain2Type_reg != 2'h0) else $error("bad input type");
	percent_range_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		ain1Val_reg <= `PCCA_PERCENT_MAX && ain2Val_reg <= `PCCA_PERCENT_MAX)
		else $error("percent above full scale");
	total_pulse_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(wrCmd && paramWrData[`PCCA_CMD_TOTAL_RST]) |=> energyTotalReset ##1
		(!energyTotalReset || $past(wrCmd && paramWrData[`PCCA_CMD_TOTAL_RST])))
		else $error("totalizer reset not pulsed");
	unused_zero_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(cmd_reg & ~`PCCA_CMD_KEEP_MASK) == 16'h0) else $error("unused bit stored");
	enable_cmd_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(wrCmd && !digEnableAssigned) ##1 !wrCmd && !digEnableAssigned ##1
		!digEnableAssigned |=> outputEnable == $past(cmd_reg[`PCCA_CMD_ENABLE], 2))
		else $error("enable does not follow command");
	port2_enable_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(digEnableAssigned && port2ReadWrite && !denSync) |=> !outputEnable)
		else $error("enabled without digital input");
	port2_local_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		port2ReadWrite |=> localSetPoint == $past(cmdLocal))
		else $error("local not from command bit");
	delay_range_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		delay_reg <= `PCCA_DELAY_MAX) else $error("delay above 90 degrees");
	bake_gate_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(enRise && offMin_reg < offTime_reg && bake_reg == BAKE_IDLE) |=> !bakeoutActive)
		else $error("bakeout without off time");

endmodule // pcca_core

// [tb/pcca_host_model.sv]
`timescale 1ns/1ps

// ******************************
// Host side of the parameter port
// ******************************
module pcca_host_model (
	input  wire logic        ref_clk,
	output logic             paramWrEn,
	output logic [3:0]       paramSel,
	output logic [15:0]      paramWrData
);
	initial begin
		paramWrEn = 1'b0;
		paramSel = 4'h0;
		paramWrData = 16'h0000;
	end

	// One-cycle strobe; data inverted afterwards so stale data is never reused
	task automatic wr(input logic [3:0] s, input logic [15:0] d);
		@(negedge ref_clk);
		paramSel = s;
		paramWrData = d;
		paramWrEn = 1'b1;
		@(negedge ref_clk);
		paramWrEn = 1'b0;
		paramWrData = ~d;
	endtask

	// Read data is registered, so it is valid one cycle after the selector
	task automatic rdsel(input logic [3:0] s);
		@(negedge ref_clk);
		paramSel = s;
		@(negedge ref_clk);
	endtask
endmodule // pcca_host_model

// [tb/testbench.sv]
`timescale 1ns/1ps

module testbench;
	import pcca_pkg::*;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic ctrlPowerOn, heatSinkHotPin, heaterBreakPin, shortedSwitchPin, currentLimitPin;
	logic digIn1Pin, digEnablePin, digLocalPin, digEnableAssigned, digLocalAssigned;
	logic port2ReadWrite, commWatchdogErr, paramWrEn;
	logic [9:0] ain1Raw, ain2Raw, lineVoltRaw;
	logic [3:0] paramSel;
	logic [15:0] paramWrData, paramRdData, v;
	logic alarmRelay, heaterBreakMonEn, shortedSwitchMonEn, outputEnable;
	logic localSetPoint, localCurrentLimit, energyTotalReset;
	logic [1:0] ain1Type, ain2Type;
	pcca_ain2_func_t ain2Function;
	logic bakeoutActive, cycleStart;
	logic countOn = 1'b0;
	int pulses = 0;
	logic [6:0] firingDelayDeg;
	int mismatches = 0;
	int num_checks = 0;
	typedef struct {logic [15:0] v; logic [15:0] m; bit [1:0] k;} pcca_exp_t;
	pcca_exp_t expQ[$];
	pcca_exp_t e;
	event obs;
	logic [15:0] rstVal [8] = '{16'h1, 16'h1, 16'h1, 16'h0, 16'h1, 16'h1, 16'h1e, 16'h3c};
	logic [15:0] good [7] = '{16'h3, 16'h2, 16'h2, 16'h7cf, 16'h7cf, 16'hff, 16'h5a};
	logic [15:0] bad [7] = '{16'h0, 16'h4, 16'h3, 16'h7d0, 16'h0, 16'h100, 16'h5b};
	logic [7:0] msk [4] = '{8'hff, 8'hb2, 8'hd4, 8'he8};
	wire [15:0] flags = {firingDelayDeg, ain1Type, energyTotalReset, localCurrentLimit,
		localSetPoint, outputEnable, shortedSwitchMonEn, heaterBreakMonEn, alarmRelay};
	wire [15:0] more = {3'h0, pulses[7:0], bakeoutActive, ain2Function, ain2Type};

	always #5 ref_clk = ~ref_clk;

	// Start pulses counted only inside a test window
	always @(negedge ref_clk)
		if (countOn && cycleStart === 1'b1)
			pulses++;

	// Short counts keep minute and step timers inside the run
	pcca_core #(.HAS_CURRENT_LIMIT(1'b1), .MINUTE_CYCLES(100), .STEP_CYCLES(10)) i_dut (.*);
	pcca_host_model i_host (.*);

	// ******************************
	// Scoreboard
	// ******************************
	task automatic cmp_word(input logic [15:0] x, input logic [15:0] g);
		num_checks++;
		if (g !== x) begin
			mismatches++;
			$display("unexpected at %0t: exp %h got %h", $time, x, g);
		end
	endtask
	task automatic cmp_flags(input logic [15:0] x, input logic [15:0] g);
		cmp_word(x, g);
	endtask
	task automatic expf(input logic [15:0] x, input logic [15:0] m);
		expQ.push_back('{x & m, m, 2'h1});
		->obs;
	endtask
	task automatic exps(input logic [15:0] x, input logic [15:0] m);
		expQ.push_back('{x & m, m, 2'h2});
		->obs;
	endtask
	task automatic rd(input logic [3:0] s, input logic [15:0] x);
		i_host.rdsel(s);
		expQ.push_back('{x, 16'hffff, 2'h0});
		->obs;
	endtask
	always @(obs) begin
		while (expQ.size() > 0) begin
			e = expQ.pop_front();
			if (e.k == 2'h2)
				cmp_flags(e.v, more & e.m);
			else if (e.k == 2'h1)
				cmp_flags(e.v, flags & e.m);
			else
				cmp_word(e.v, paramRdData);
		end
	end

	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		#100us;
		mismatches++;
		complete_run();
	end

	// ******************************
	// Tests
	// ******************************
	initial begin
		{ctrlPowerOn, heatSinkHotPin, heaterBreakPin, shortedSwitchPin, currentLimitPin} = 5'h10;
		{digIn1Pin, digEnablePin, digLocalPin, digEnableAssigned, digLocalAssigned} = 5'h00;
		{port2ReadWrite, commWatchdogErr} = 2'h0;
		{ain1Raw, ain2Raw, lineVoltRaw} = 30'h0;
		void'($urandom(89115));
		repeat (3) @(negedge ref_clk);
		sys_rst = 1'b0;
		repeat (3) @(negedge ref_clk);
		expf(16'h7883, 16'hffff);
		exps(16'h0001, 16'h001f);
		for (int j = 0; j < 8; j++)
			rd(4'(j + 1), rstVal[j]);
		for (int i = 0; i < 8; i++) begin
			v = {11'h0, i[2], 1'b0, i[1], i[0], 1'b0};
			i_host.wr(4'h0, v | (16'($urandom) & 16'hf7e9));
			repeat (3) @(negedge ref_clk);
			expf({10'h0, v[4], v[1], v[2], 3'h0}, 16'h0038);
			rd(4'h0, v);
		end
		i_host.wr(4'h0, 16'h0800);
		expf(16'h0040, 16'h0040);
		@(negedge ref_clk);
		expf(16'h0000, 16'h0040);
		rd(4'h0, 16'h0000);
		{port2ReadWrite, digEnableAssigned, digEnablePin, digLocalAssigned, digLocalPin} = 5'h1f;
		i_host.wr(4'h0, 16'h0000);
		repeat (3) @(negedge ref_clk);
		expf(16'h0000, 16'h0018);
		i_host.wr(4'h0, 16'h0006);
		repeat (3) @(negedge ref_clk);
		expf(16'h0018, 16'h0018);
		port2ReadWrite = 1'b0;
		i_host.wr(4'h0, 16'h0000);
		repeat (3) @(negedge ref_clk);
		expf(16'h0018, 16'h0018);
		{digEnableAssigned, digLocalAssigned} = 2'h0;
		for (int s = 0; s < 8; s++) begin
			i_host.wr(4'h1, 16'(s));
			for (int f = 0; f < 4; f++) begin
				{heatSinkHotPin, heaterBreakPin, shortedSwitchPin, currentLimitPin} = 4'h8 >> f;
				repeat (4) @(negedge ref_clk);
				expf({13'h0, msk[2][s], msk[1][s], ~msk[f][s]}, 16'h0007);
			end
			{heatSinkHotPin, heaterBreakPin, shortedSwitchPin, currentLimitPin} = 4'h0;
			rd(4'h1, 16'(s));
		end
		ctrlPowerOn = 1'b0;
		repeat (3) @(negedge ref_clk);
		expf(16'h0000, 16'h0001);
		ctrlPowerOn = 1'b1;
		i_host.wr(4'h1, 16'h0008);
		commWatchdogErr = 1'b1;
		repeat (3) @(negedge ref_clk);
		expf(16'h0000, 16'h0001);
		commWatchdogErr = 1'b0;
		repeat (3) @(negedge ref_clk);
		expf(16'h0001, 16'h0001);
		for (int j = 0; j < 7; j++) begin
			i_host.wr(4'(j + 2), good[j]);
			i_host.wr(4'(j + 2), bad[j]);
			rd(4'(j + 2), good[j]);
		end
		expf(16'hb580, 16'hff80);
		exps(16'h000a, 16'h000f);
		ain1Raw = 10'($urandom_range(1000));
		ain2Raw = 10'h3ff;
		lineVoltRaw = 10'($urandom);
		digIn1Pin = 1'b1;
		repeat (3) @(negedge ref_clk);
		rd(4'h9, {6'h0, ain1Raw});
		rd(4'ha, 16'h03e8);
		rd(4'hb, {6'h0, lineVoltRaw});
		rd(4'hc, 16'h0001);
		rd(4'hf, 16'h0000);
		// Long off time keeps the bakeout gate shut
		i_host.wr(4'h0, 16'h0004);
		repeat (3) @(negedge ref_clk);
		exps(16'h0000, 16'h0010);
		i_host.wr(4'h5, 16'h0001);
		i_host.wr(4'h6, 16'h0002);
		i_host.wr(4'h0, 16'h0000);
		repeat (110) @(negedge ref_clk);
		i_host.wr(4'h0, 16'h0004);
		repeat (3) @(negedge ref_clk);
		exps(16'h0010, 16'h0010);
		rd(4'hd, 16'h0050);
		repeat (150) @(negedge ref_clk);
		exps(16'h0010, 16'h0010);
		repeat (60) @(negedge ref_clk);
		exps(16'h0000, 16'h0010);
		// Two steps per cycle: ten starts in 200 clocks, none at zero
		i_host.wr(4'h7, 16'h0002);
		repeat (40) @(negedge ref_clk);
		countOn <= 1'b1;
		repeat (200) @(negedge ref_clk);
		countOn <= 1'b0;
		@(negedge ref_clk);
		exps(16'h0140, 16'h1fe0);
		i_host.wr(4'h7, 16'h0000);
		repeat (40) @(negedge ref_clk);
		countOn <= 1'b1;
		repeat (100) @(negedge ref_clk);
		countOn <= 1'b0;
		@(negedge ref_clk);
		exps(16'h0140, 16'h1fe0);
		// Let the scoreboard drain the last notes
		@(negedge ref_clk);
		complete_run();
	end
endmodule // testbench
